// *** hdl/bsx_area_dec.sv ***
// Chip select area decoder for normal (unbanked) accesses.
`timescale 1ns/10ps
`include "bsx_consts.svh"
`default_nettype none
module bsx_area_dec #(
  parameter logic [19:0] CS0_LO = 20'hc0000,
  parameter logic [19:0] CS1_LO = 20'h28000,
  parameter logic [19:0] CS1_HI_1MB = 20'hbffff,
  parameter logic [19:0] CS2_LO = 20'h10000,
  parameter logic [19:0] CS2_HI = 20'h27fff,
  parameter logic [19:0] CS3_LO = 20'h04000,
  parameter logic [19:0] CS3_HI = 20'h07fff
) (
  input wire logic [19:0] addr_i,
  input wire logic map_4mb_i,
  bsx_cs_if.dec cs
);
  // In the banked map the second area stops short of the window.
  wire [19:0] cs1_hi = map_4mb_i ? `BSX_CS1_4MB_LAST : CS1_HI_1MB; // RQ6
  assign cs.area_hit[0] = addr_i >= CS0_LO;
  assign cs.area_hit[1] = (addr_i >= CS1_LO) && (addr_i <= cs1_hi);
  assign cs.area_hit[2] = (addr_i >= CS2_LO) && (addr_i <= CS2_HI);
  assign cs.area_hit[3] = (addr_i >= CS3_LO) && (addr_i <= CS3_HI);
endmodule
`default_nettype wire

// *** hdl/bsx_expand.sv ***
// Memory space expansion: bank register, chip select and address drive.
// Function
// RQ1 - The bank register only acts in memory expansion or microprocessor mode.
// RQ2 - Writes to the bank register are taken only in 4-MB mode.
// RQ3 - In 1-MB mode external areas are told apart only by chip selects.
// RQ4 - In 4-MB mode three bank bits pick the data bank.
// RQ5 - The offset bit moves the external address up by 40000h.
// RQ6 - Outside the window chip selects act as in 1-MB mode, area 1 ends 3FFFFh.
// RQ7 - Window accesses 40000h to BFFFFh drive the area 0 select low.
// RQ8 - Window accesses drive selects 3 to 1 with the bank bits.
// RQ9 - Software keeps code out of banks 0 to 6.
// RQ10 - With the expand bit clear, banks lie 512 KB apart and offset spans them.
// RQ11 - In expansion mode with the expand bit set, offset picks a 256 KB half.
// RQ12 - Window address is CPU address plus 40000h when offset is set.
`timescale 1ns/10ps
`include "bsx_consts.svh"
`default_nettype none
module bsx_expand (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [1:0] processor_mode_field_i,
  input wire logic [1:0] space_size_mode_field_i,
  input wire logic internal_area_expand_bit_i,
  input wire logic data_bank_reg_we_i,
  input wire logic [3:0] data_bank_reg_wdata_i,
  input wire logic bus_access_i,
  input wire logic external_i,
  input wire bsx_pkg::bsx_addr_t cpu_addr_i,
  output logic [3:0] data_bank_reg_o,
  output logic banked_o,
  output logic area0_chip_select_n_o,
  output logic [2:0] bank_number_selects_o,
  output logic [19:0] ext_addr_o
);
  import bsx_pkg::*;

  // ==========================================================
  // Mode decode
  logic [3:0] data_bank_reg_q;
  logic [3:0] data_bank_reg_d;
  wire ext_mode = (processor_mode_field_i == `BSX_PM_EXPAND) ||
                  (processor_mode_field_i == `BSX_PM_MICRO); // RQ1
  wire mode_exp = processor_mode_field_i == `BSX_PM_EXPAND;
  wire size_4mb = space_size_mode_field_i == `BSX_SZ_4MB;
  bsx_map_e map;
  assign map = (ext_mode && size_4mb) ? BSX_MAP_4MB : BSX_MAP_1MB; // RQ3
  wire map_4mb = map == BSX_MAP_4MB; // RQ4
  wire bank_ofs = data_bank_reg_q[`BSX_OFS_BIT];
  wire [2:0] bank_sel = data_bank_reg_q[2:0];
  // Half-bank mode limits the window to 40000h..7FFFFh in each half.
  wire half_mode = mode_exp && internal_area_expand_bit_i; // RQ11
  wire [19:0] win_hi = half_mode ? (`BSX_WIN_LO | `BSX_HALF_MASK) :
                       `BSX_WIN_HI;
  wire in_win = (cpu_addr_i >= `BSX_WIN_LO) && (cpu_addr_i <= win_hi);
  wire banked = map_4mb && in_win && bus_access_i && external_i; // RQ7

  // ==========================================================
  // Bank register
  // Writes outside 4-MB mode are dropped so a stale bank is never armed.
  assign data_bank_reg_d = (data_bank_reg_we_i && size_4mb) ?
                           data_bank_reg_wdata_i : data_bank_reg_q; // RQ2
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      data_bank_reg_q <= `BSX_DBR_RESET;
    end else begin
      data_bank_reg_q <= data_bank_reg_d;
    end
  end

  // ==========================================================
  // Area decode and output drive
  bsx_cs_if cs_bus ();
  bsx_area_dec u_dec (
    .addr_i(cpu_addr_i),
    .map_4mb_i(map_4mb),
    .cs(cs_bus)
  );
  wire [3:0] norm_n = (bus_access_i && external_i) ?
                      ~cs_bus.area_hit : 4'hf; // RQ6
  // Offset adds 40000h; in half mode this lands in the upper 256 KB.
  // The sum stays 20 bits on purpose: the window never exceeds FFFFFh.
  wire [19:0] ofs_addr = cpu_addr_i + `BSX_OFFSET; // RQ5 RQ12
  // Past BFFFFh the access carries into the next bank and the address
  // folds back by 80000h, so data straddling a bank stays contiguous.
  wire ofs_wrap = bank_ofs && (ofs_addr[19:18] == 2'h3); // RQ10
  wire [19:0] win_addr = ofs_wrap ? {1'b0, ofs_addr[18:0]} : ofs_addr; // RQ10
  wire [2:0] win_bank = bank_sel + {2'h0, ofs_wrap}; // RQ8 RQ10
  wire [19:0] addr_d = (banked && bank_ofs) ? win_addr : cpu_addr_i; // RQ12
  wire cs0_d = banked ? 1'b0 : norm_n[0]; // RQ7
  wire [2:0] csb_d = banked ? win_bank : norm_n[3:1]; // RQ8

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      area0_chip_select_n_o <= 1'b1;
      bank_number_selects_o <= 3'h7;
      ext_addr_o <= 20'h00000;
      banked_o <= 1'b0;
    end else begin
      area0_chip_select_n_o <= cs0_d;
      bank_number_selects_o <= csb_d;
      ext_addr_o <= addr_d;
      banked_o <= banked;
    end
  end
  assign data_bank_reg_o = data_bank_reg_q;

  // ==========================================================
  // Checks
  property p_wr_gate;
    @(posedge clock_i) disable iff (srst_i)
      (data_bank_reg_we_i && !size_4mb) |=> $stable(data_bank_reg_q);
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("bank write leaked"); // RQ2
  property p_wr_take;
    @(posedge clock_i) disable iff (srst_i)
      (data_bank_reg_we_i && size_4mb) |=>
      data_bank_reg_q == $past(data_bank_reg_wdata_i);
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("bank write lost"); // RQ2
  property p_mode_gate;
    @(posedge clock_i) disable iff (srst_i)
      !ext_mode |=> !banked_o;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("bank in bad mode"); // RQ1
  property p_cs0_low;
    @(posedge clock_i) disable iff (srst_i)
      banked |=> !area0_chip_select_n_o;
  endproperty
  a_cs0_low: assert property (p_cs0_low) else $error("cs0 not low"); // RQ7
  property p_bank_pins;
    @(posedge clock_i) disable iff (srst_i)
      banked |=> bank_number_selects_o == 3'($past(bank_sel) +
      3'($past(bank_ofs) && ($past(cpu_addr_i) >= 20'h80000)));
  endproperty
  a_bank_pins: assert property (p_bank_pins) else $error("bank pins wrong"); // RQ8
  property p_ofs_addr;
    @(posedge clock_i) disable iff (srst_i)
      (banked && bank_ofs) |=>
      ext_addr_o == (($past(cpu_addr_i) >= 20'h80000) ?
      $past(cpu_addr_i) - 20'h40000 : $past(cpu_addr_i) + 20'h40000);
  endproperty
  a_ofs_addr: assert property (p_ofs_addr) else $error("offset wrong"); // RQ5
  property p_plain_addr;
    @(posedge clock_i) disable iff (srst_i)
      !(banked && bank_ofs) |=> ext_addr_o == $past(cpu_addr_i);
  endproperty
  a_plain_addr: assert property (p_plain_addr) else $error("addr wrong"); // RQ12
  property p_1mb_cs;
    @(posedge clock_i) disable iff (srst_i)
      (!map_4mb && bus_access_i && external_i) |=>
      {bank_number_selects_o, area0_chip_select_n_o} ==
      $past(~cs_bus.area_hit);
  endproperty
  a_1mb_cs: assert property (p_1mb_cs) else $error("1MB cs wrong"); // RQ3
  property p_cs1_end;
    @(posedge clock_i) disable iff (srst_i)
      (map_4mb && bus_access_i && external_i &&
       cpu_addr_i > 20'h3ffff && cpu_addr_i < 20'hc0000) |=>
      !(bank_number_selects_o[0] == 1'b0 && banked_o == 1'b0);
  endproperty
  a_cs1_end: assert property (p_cs1_end) else $error("cs1 overrun"); // RQ6
  property p_idle_high;
    @(posedge clock_i) disable iff (srst_i)
      !(bus_access_i && external_i) |=>
      (area0_chip_select_n_o && (bank_number_selects_o == 3'h7));
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("select not idle"); // RQ3
  property p_half_win;
    @(posedge clock_i) disable iff (srst_i)
      (half_mode && map_4mb && bus_access_i && external_i &&
       cpu_addr_i >= 20'h80000 && cpu_addr_i <= 20'hbffff) |=> !banked_o;
  endproperty
  a_half_win: assert property (p_half_win) else $error("half window"); // RQ11
endmodule
`default_nettype wire

// *** shared/bsx_consts.svh ***
// Constants for the bank-switched memory expansion block.
`ifndef BSX_CONSTS_SVH
`define BSX_CONSTS_SVH
`define BSX_PM_EXPAND 2'h1
`define BSX_PM_MICRO 2'h3
`define BSX_SZ_4MB 2'h3
`define BSX_SZ_1MB 2'h0
`define BSX_WIN_LO 20'h40000
`define BSX_WIN_HI 20'hbffff
`define BSX_CS1_4MB_LAST 20'h3ffff
`define BSX_OFFSET 20'h40000
`define BSX_HALF_MASK 20'h3ffff
`define BSX_DBR_RESET 4'h0
`define BSX_OFS_BIT 3
`endif

// *** shared/bsx_cs_if.sv ***
// Carries area decode results from the decoder to the top.
`timescale 1ns/10ps
`default_nettype none
interface bsx_cs_if;
  logic [3:0] area_hit;
  modport dec (output area_hit);
  modport top (input area_hit);
endinterface
`default_nettype wire

// *** shared/bsx_pkg.sv ***
// Types for the bank-switched memory expansion block.
package bsx_pkg;
  typedef logic [19:0] bsx_addr_t;
  typedef logic [2:0] bsx_bank_t;
  typedef enum logic [1:0] {
    BSX_MAP_1MB = 2'h1,
    BSX_MAP_4MB = 2'h2
  } bsx_map_e;
endpackage

// *** test/bsx_expand_tb.sv ***
// Self-checking bench for the bank-switched memory expansion block.
`timescale 1ns/10ps
`default_nettype none
module bsx_expand_tb;
  import bsx_pkg::*;
  typedef struct packed {
    logic ck, ka, bk, cs0n;
    logic [2:0] sel;
    logic [19:0] ea;
  } bsx_exp_s;
  logic clk = 0, rst = 1, xb = 0, we = 0, bk, cs0n, rsel;
  logic [1:0] pm = 0, sz = 0, ax = 0;
  logic [3:0] wd = 0, data_bank_reg, mdbr = 0;
  bsx_addr_t addr = 0;
  logic [19:0] ea;
  logic [2:0] sel;
  logic [21:0] ra, er;
  int err_count = 0, checks_done = 0;
  bsx_exp_s x;
  logic [19:0] ca [11] = '{20'h03fff, 20'h04000, 20'h07fff, 20'h10000,
    20'h27fff, 20'h28000, 20'h3ffff, 20'h40000, 20'hbffff, 20'hc0000,
    20'hfffff};
  bsx_expand bsx_expand_inst (.clock_i(clk), .srst_i(rst),
    .processor_mode_field_i(pm), .space_size_mode_field_i(sz),
    .internal_area_expand_bit_i(xb), .data_bank_reg_we_i(we),
    .data_bank_reg_wdata_i(wd), .bus_access_i(ax[1]), .external_i(ax[0]),
    .cpu_addr_i(addr), .data_bank_reg_o(data_bank_reg), .banked_o(bk),
    .area0_chip_select_n_o(cs0n), .bank_number_selects_o(sel),
    .ext_addr_o(ea));
  bsx_rom_model bsx_rom_model_inst (.cs_n_i(cs0n), .hi_i(sel), .addr_i(ea),
    .sel_o(rsel), .rom_addr_o(ra));
  initial begin
    forever #20 clk = ~clk;
  end
  // Where the mode leaves the select pins open to reading, ck is dropped.
  function automatic bsx_exp_s f_exp(input logic [1:0] p, s,
      input logic h, a, input logic [19:0] d, input logic [3:0] r);
    bsx_exp_s e;
    logic m4;
    logic w;
    m4 = (p == 2'h1 || p == 2'h3) && s == 2'h3;
    w = r[3] && d >= 20'h80000;
    e = '{1'b1, 1'b1, 1'b0, d < 20'hc0000, 3'h7, d};
    e.sel = ~{d >= 20'h04000 && d <= 20'h07fff, d >= 20'h10000 &&
      d <= 20'h27fff, d >= 20'h28000 && d <= (m4 ? 20'h3ffff : 20'hbffff)};
    if (m4 && d >= 20'h40000 && d <= (p == 2'h1 && h ? 20'h7ffff : 20'hbffff))
      e = '{1'b1, 1'b1, 1'b1, 1'b0, 3'(r[2:0] + 3'(w)),
        w ? d - 20'h40000 : d + (r[3] ? 20'h40000 : 20'h0)};
    else if (s == 2'h3 && d >= 20'h40000 && d <= 20'hbffff)
      e.ck = 1'b0;
    if (!a)
      e = '{1'b1, 1'b0, 1'b0, 1'b1, 3'h7, d};
    return e;
  endfunction
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input logic [1:0] p, s, input logic h, w,
      input logic [3:0] d, input logic [1:0] a, input logic [19:0] ad);
    {pm, sz, xb, we, wd, ax, addr} = {p, s, h, w, d, a, ad};
    x = f_exp(p, s, h, &a, ad, mdbr);
    er = {mdbr[2:0], 19'h0} + ad - 22'h40000 + (mdbr[3] ? 22'h40000 : 22'h0);
    if (w && s == 2'h3) mdbr = d;
    @(posedge clk);
    #1;
    chk(data_bank_reg === mdbr, "bank register");
    chk(bk === x.bk, "banked flag");
    if (x.ck) chk({cs0n, sel} === {x.cs0n, x.sel}, "selects");
    if (x.ka) chk(ea === x.ea, "address");
    if (x.bk) chk(rsel && ra === er, "rom address");
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(76616));
    repeat (10) @(posedge clk);
    #2;
    chk({data_bank_reg, bk, cs0n, sel, ea} === {4'h0, 1'b0, 1'b1, 3'h7, 20'h0}, "reset");
    rst = 1'b0;
    cyc(2'h3, 2'h0, 1'b0, 1'b1, 4'hf, 2'h3, 20'h50000);
    for (int b = 0; b < 16; b++) begin
      cyc(2'h3, 2'h3, 1'b0, 1'b1, 4'(b), 2'h2, 20'h0);
      cyc(2'h3, 2'h3, 1'b0, 1'b0, 4'h0, 2'h3, 20'h40000);
      cyc(2'h1, 2'h3, 1'b0, 1'b0, 4'h0, 2'h3, 20'hbffff);
      cyc(2'h1, 2'h3, 1'b1, 1'b0, 4'h0, 2'h3, 20'h7ffff);
      cyc(2'h2, 2'h3, 1'b0, 1'b0, 4'h0, 2'h3, 20'h60000);
    end
    foreach (ca[i]) begin
      cyc(2'h3, 2'h0, 1'b0, 1'b0, 4'h0, 2'h3, ca[i]);
      cyc(2'h3, 2'h3, 1'b0, 1'b0, 4'h0, 2'h3, ca[i]);
    end
    repeat (1500)
      cyc(2'($urandom), $urandom % 2 ? 2'h3 : 2'($urandom), 1'($urandom),
        $urandom % 4 == 0, 4'($urandom), $urandom % 8 ? 2'h3 : 2'($urandom),
        20'($urandom));
    end_sim;
  end
  initial begin
    #200000;
    err_count++;
    end_sim;
  end
endmodule
`default_nettype wire

// *** test/bsx_rom_model.sv ***
// Behavioural 4-MB ROM wired to the banked select pins.
`timescale 1ns/10ps
`default_nettype none
module bsx_rom_model (
  input wire logic cs_n_i,
  input wire logic [2:0] hi_i,
  input wire logic [19:0] addr_i,
  output logic sel_o,
  output logic [21:0] rom_addr_o
);
  // Bus A18 is left open on the part, so it takes no part in the address.
  assign rom_addr_o = {hi_i, addr_i[19], addr_i[17:0]};
  // Banks 0 to 6 hold data only; the bench never fetches code from them.
  assign sel_o = !cs_n_i;
endmodule
`default_nettype wire
